// *** verilog/hms_host.sv ***
// Host-side controller driving the management port over SPI, two-wire or MDIO.
`timescale 1ns/1ps
`default_nettype none
module hms_host import hms_pkg::*; #(
  parameter int HALF_CYC = HMS_HALF_CYC
) (
  // Clock, reset and clock enable.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Request and answer port.
  input wire logic i_req_valid,
  input wire hms_req_t i_req,
  input wire logic i_inband_active,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output hms_rsp_t o_rsp,
  // SPI pins.
  output logic o_spi_sclk,
  output logic o_spi_chip_select_n,
  output logic o_serial_in_line,
  input wire logic i_serial_out_line,
  // Two-wire pins, both open-drain.
  output logic o_twi_scl_o,
  output logic o_twi_scl_oe,
  output logic o_twi_sda_o,
  output logic o_twi_sda_oe,
  input wire logic i_twi_sda_i,
  // MDIO pins.
  output logic o_mdc,
  output logic o_mdio_o,
  output logic o_mdio_oe,
  input wire logic i_mdio_i
);

  // The serial clock must never beat faster than the slowest device allows.
  if (HALF_CYC < HMS_HALF_CYC) begin : g_half_chk
    $error("HALF_CYC too small for the management clock limit");
  end

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_START = 7'b0000010,
    ST_LOW = 7'b0000100,
    ST_HIGH = 7'b0001000,
    ST_RESTART = 7'b0010000,
    ST_STOP = 7'b0100000,
    ST_DONE = 7'b1000000
  } hms_state_t;
  localparam int CW = $clog2(HALF_CYC + 1);

  hms_state_t state;
  hms_req_t req;
  logic [CW-1:0] div;
  logic [63:0] tx, rel, chk;
  logic [6:0] left;
  logic [15:0] rx;
  logic [2:0] sync_a, sync_b;
  logic tick, sub, seg2, err, clk_lvl, dat, den, cs_n, sin, bad_req;

  // Two-flop synchronisers for the three returning data pins.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync_a <= 3'h7;
      sync_b <= 3'h7;
    end else if (i_ce) begin
      sync_a <= {i_mdio_i, i_twi_sda_i, i_serial_out_line};
      sync_b <= sync_a;
    end
  end

  // The data line of the active mode, seen only after synchronising.
  always_comb begin
    case (req.mode)
      HMS_MODE_TWI: sin = sync_b[1];
      HMS_MODE_MDIO: sin = sync_b[2];
      default: sin = sync_b[0];
    endcase
  end

  // MDIO is withheld during in-band access and for PHYs outside 1 to 5.
  assign bad_req = (i_req.mode == HMS_MODE_MDIO) &&
                   (i_inband_active ||
                    i_req.addr[9:5] < HMS_MDIO_PHY_MIN ||
                    i_req.addr[9:5] > HMS_MDIO_PHY_MAX);

  // Half-period divider; it runs only while a transfer is under way.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div <= '0;
      tick <= 1'b0;
    end else if (i_ce) begin
      tick <= 1'b0;
      if (state == ST_IDLE || state == ST_DONE) begin
        div <= '0;
      end else if (div == CW'(HALF_CYC - 1)) begin
        div <= '0;
        tick <= 1'b1;
      end else begin
        div <= div + 1'b1;
      end
    end
  end

  // Frame sequencer: every bit is driven in the low half, sampled in the high.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
      req <= '0;
      tx <= '0;
      rel <= '0;
      chk <= '0;
      left <= '0;
      rx <= '0;
      sub <= 1'b0;
      seg2 <= 1'b0;
      err <= 1'b0;
      clk_lvl <= 1'b0;
      dat <= 1'b1;
      den <= 1'b0;
      cs_n <= 1'b1;
      o_req_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp <= '0;
    end else if (i_ce) begin
      o_rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_req_ready <= 1'b1;
          clk_lvl <= 1'b0;
          if (i_req_valid && o_req_ready) begin
            o_req_ready <= 1'b0;
            req <= i_req;
            err <= 1'b0;
            sub <= 1'b0;
            seg2 <= 1'b0;
            rx <= '0;
            if (bad_req) begin
              err <= 1'b1;
              state <= ST_DONE;
            end else begin
              state <= ST_START;
              case (i_req.mode)
                HMS_MODE_TWI: begin
                  // Start condition: data falls while the clock is high.
                  clk_lvl <= 1'b1;
                  dat <= 1'b0;
                  den <= 1'b1;
                  tx <= {HMS_TWI_ADDR, 1'b0, 1'b1, i_req.addr[15:8], 1'b1,
                         i_req.addr[7:0], 1'b1,
                         i_req.write ? i_req.wdata[7:0] : 8'hFF, 1'b1,
                         28'h0};
                  chk <= {8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1, 8'h0,
                          i_req.write, 28'h0};
                  rel <= {8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1,
                          28'h0};
                  left <= i_req.write ? HMS_TWI_WR_BITS : HMS_TWI_RD1_BITS;
                end
                HMS_MODE_MDIO: begin
                  tx <= {HMS_MDIO_PRE, HMS_MDIO_ST,
                         i_req.write ? HMS_MDIO_OP_WR : HMS_MDIO_OP_RD,
                         i_req.addr[9:5], i_req.addr[4:0],
                         i_req.write ? HMS_MDIO_TA_WR : 2'h3,
                         i_req.write ? i_req.wdata : 16'hFFFF};
                  rel <= {46'h0, {18{~i_req.write}}};
                  chk <= '0;
                  left <= HMS_MDIO_BITS;
                end
                default: begin
                  cs_n <= 1'b0;
                  tx <= {i_req.write ? HMS_SPI_CMD_WR : HMS_SPI_CMD_RD,
                         HMS_SPI_ADDR_HI, i_req.addr, HMS_SPI_TA,
                         i_req.write ? i_req.wdata[7:0] : 8'h00,
                         24'h0};
                  rel <= '0;
                  chk <= '0;
                  left <= HMS_SPI_BITS;
                end
              endcase
            end
          end
        end
        ST_START: begin
          if (tick) begin
            clk_lvl <= 1'b0;
            dat <= tx[63];
            den <= ~rel[63];
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (tick) begin
            clk_lvl <= 1'b1;
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            // Sample late in the high half, where the far end's bit is settled.
            rx <= {rx[14:0], sin};
            if (chk[63] && sin) begin
              err <= 1'b1;
            end
            tx <= {tx[62:0], 1'b0};
            rel <= {rel[62:0], 1'b0};
            chk <= {chk[62:0], 1'b0};
            left <= left - 1'b1;
            clk_lvl <= 1'b0;
            if (left == 7'h01) begin
              sub <= 1'b0;
              if (req.mode == HMS_MODE_TWI && !req.write && !seg2) begin
                dat <= 1'b1;
                den <= 1'b0;
                state <= ST_RESTART;
              end else begin
                dat <= (req.mode != HMS_MODE_TWI);
                den <= (req.mode == HMS_MODE_TWI);
                state <= ST_STOP;
              end
            end else begin
              dat <= tx[62];
              den <= ~rel[62];
              state <= ST_LOW;
            end
          end
        end
        ST_RESTART: begin
          // Repeated start before the read half of a two-wire access.
          if (tick) begin
            sub <= 1'b1;
            clk_lvl <= 1'b1;
            if (sub) begin
              dat <= 1'b0;
              den <= 1'b1;
              seg2 <= 1'b1;
              tx <= {HMS_TWI_ADDR, 1'b1, 1'b1, 8'hFF, 1'b1, 46'h0};
              rel <= {8'h0, 1'b1, 9'h1FF, 46'h0};
              chk <= {8'h0, 1'b1, 55'h0};
              left <= HMS_TWI_RD2_BITS;
              state <= ST_START;
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            sub <= 1'b1;
            clk_lvl <= (req.mode == HMS_MODE_TWI);
            if (sub) begin
              dat <= 1'b1;
              den <= 1'b0;
              cs_n <= 1'b1;
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          o_rsp_valid <= 1'b1;
          o_rsp.err <= err;
          if (req.write || err) begin
            o_rsp.rdata <= 16'h0000;
          end else if (req.mode == HMS_MODE_MDIO) begin
            o_rsp.rdata <= rx;
          end else if (req.mode == HMS_MODE_TWI) begin
            o_rsp.rdata <= {8'h00, rx[8:1]};
          end else begin
            o_rsp.rdata <= {8'h00, rx[7:0]};
          end
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin flops; an idle mode leaves its lines released, clocks low.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      {o_spi_sclk, o_serial_in_line, o_mdc, o_mdio_oe} <= 4'h0;
      {o_twi_scl_o, o_twi_scl_oe, o_twi_sda_o, o_twi_sda_oe} <= 4'h0;
      {o_spi_chip_select_n, o_mdio_o} <= 2'h3;
    end else if (i_ce) begin
      o_spi_sclk <= (req.mode == HMS_MODE_SPI) && clk_lvl;
      o_spi_chip_select_n <= cs_n;
      o_serial_in_line <= (req.mode == HMS_MODE_SPI) && den && dat;
      o_twi_scl_oe <= (req.mode == HMS_MODE_TWI) && !clk_lvl &&
                      (state != ST_IDLE) && (state != ST_DONE);
      o_twi_sda_oe <= (req.mode == HMS_MODE_TWI) && den && !dat;
      o_mdc <= (req.mode == HMS_MODE_MDIO) && clk_lvl;
      o_mdio_o <= dat;
      o_mdio_oe <= (req.mode == HMS_MODE_MDIO) && den;
    end
  end

endmodule : hms_host
`default_nettype wire

// *** include/hms_pkg.sv ***
// Constants and carrier types for the host-side management serial controller.
// Notes on behaviour
// - The SPI master keeps the serial clock low whenever no operation runs.
// - An SPI operation spans chip select low, from its fall to its rise.
// - One SPI access is 27 command/address bits, 5 turnaround bits, 8 data bits.
// - Every SPI command, address and data field goes most significant bit first.
// - Inputs are sampled on rising serial clock, outputs change on falling edges.
// - SPI command 011 reads, 010 writes, followed by the address bits.
// - Two-wire transfers carry a 16-bit register address then 8-bit data.
// - Host never uses MDC/MDIO while in-band register access is active; the code checks this only when a request is taken, so a running frame goes on.
// - The management clock never runs faster than 5 MHz.
// - MDIO frame: 32 ones, 01, opcode, PHY and register address, turnaround, data.
package hms_pkg;

  // Mode codes of the management port.
  localparam logic [1:0] HMS_MODE_SPI = 2'h0;
  localparam logic [1:0] HMS_MODE_TWI = 2'h1;
  localparam logic [1:0] HMS_MODE_MDIO = 2'h2;

  // Clock rate and the shortest legal half period of the serial clock.
  localparam int HMS_CLK_HZ = 250_000_000;
  localparam int HMS_SER_MAX_HZ = 5_000_000;
  localparam int HMS_HALF_CYC = (HMS_CLK_HZ + 2 * HMS_SER_MAX_HZ - 1) /
                                (2 * HMS_SER_MAX_HZ);

  // SPI field codes and lengths.
  localparam logic [2:0] HMS_SPI_CMD_RD = 3'h3;
  localparam logic [2:0] HMS_SPI_CMD_WR = 3'h2;
  localparam logic [7:0] HMS_SPI_ADDR_HI = 8'h00;
  localparam logic [4:0] HMS_SPI_TA = 5'h00;
  localparam logic [6:0] HMS_SPI_BITS = 7'h28;

  // Two-wire slave address and frame lengths.
  localparam logic [6:0] HMS_TWI_ADDR = 7'h5F;
  localparam logic [6:0] HMS_TWI_WR_BITS = 7'h24;
  localparam logic [6:0] HMS_TWI_RD1_BITS = 7'h1B;
  localparam logic [6:0] HMS_TWI_RD2_BITS = 7'h12;

  // MDIO frame fields.
  localparam logic [31:0] HMS_MDIO_PRE = 32'hFFFF_FFFF;
  localparam logic [1:0] HMS_MDIO_ST = 2'h1;
  localparam logic [1:0] HMS_MDIO_OP_RD = 2'h2;
  localparam logic [1:0] HMS_MDIO_OP_WR = 2'h1;
  localparam logic [1:0] HMS_MDIO_TA_WR = 2'h2;
  localparam logic [4:0] HMS_MDIO_PHY_MIN = 5'h01;
  localparam logic [4:0] HMS_MDIO_PHY_MAX = 5'h05;
  localparam logic [6:0] HMS_MDIO_BITS = 7'h40;

  // One register access request.
  typedef struct packed {
    logic [1:0] mode;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hms_req_t;

  // The answer to one request.
  typedef struct packed {
    logic err;
    logic [15:0] rdata;
  } hms_rsp_t;

endpackage : hms_pkg

// *** testbench/hms_chk.sv ***
// Port checker for the host-side management serial controller.
`timescale 1ns/1ps
`default_nettype none
module hms_chk import hms_pkg::*; (
  // Clock, reset and request side.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire hms_req_t i_req,
  input wire logic i_inband_active,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire hms_rsp_t o_rsp,
  // Serial pins.
  input wire logic o_spi_sclk,
  input wire logic o_spi_chip_select_n,
  input wire logic o_serial_in_line,
  input wire logic o_mdc
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Taken requests, and MDIO ones that must be turned away at once.
  logic take;
  logic bad;
  assign take = i_req_valid && o_req_ready;
  assign bad = take && i_req.mode == HMS_MODE_MDIO && (i_inband_active ||
               i_req.addr[9:5] == 5'h00 || i_req.addr[9:5] > 5'h05);
  property p_idle; o_spi_chip_select_n |-> !o_spi_sclk; endproperty
  a_idle: assert property (p_idle) else $error("Clock while deselected");
  property p_hold; o_spi_sclk && $past(o_spi_sclk) |-> $stable(o_serial_in_line);
  endproperty
  a_hold: assert property (p_hold) else $error("Data moved in high");
  property p_ref; bad |-> ##2 o_rsp_valid && o_rsp.err; endproperty
  a_ref: assert property (p_ref) else $error("No refusal");
  property p_quiet; bad |=> !o_mdc [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("Refused frame ran");
  property p_start; take && i_req.mode == HMS_MODE_SPI |-> ##[1:4]
    !o_spi_chip_select_n; endproperty
  a_start: assert property (p_start) else $error("No select");
  property p_pulse; o_rsp_valid |=> !o_rsp_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("Answer not a pulse");
  property p_busy; take |=> !o_req_ready; endproperty
  a_busy: assert property (p_busy) else $error("Ready after take");
  property p_rbusy; o_rsp_valid |-> !o_req_ready; endproperty
  a_rbusy: assert property (p_rbusy) else $error("Ready with answer");
  c_spi: cover property (take && i_req.mode == HMS_MODE_SPI);
  c_mdio: cover property (take && i_req.mode == HMS_MODE_MDIO && !bad);
  c_err: cover property (o_rsp_valid && o_rsp.err);
endmodule : hms_chk
bind hms_host hms_chk i_chk (.*);
`default_nettype wire

// *** testbench/hms_dev_model.sv ***
// Behavioural model of the managed device behind the SPI and MDIO pins.
`timescale 1ns/1ps
`default_nettype none
module hms_dev_model import hms_pkg::*; (
  // SPI pins.
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  // MDIO pins.
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio_pull
);
  // The strapped mode is whichever the host drives; one byte space serves all.
  logic [7:0] mem [0:65535];
  logic [39:0] ssh;
  logic [63:0] mh;
  logic [15:0] sa, ma, rd;
  logic [7:0] sb;
  logic [2:0] scmd;
  logic sq = 1'b0, sdrv = 1'b0, mrd = 1'b0, mwr = 1'b0, ok;
  int sn = 0, mn = 0;
  function automatic logic [7:0] rdb(input logic [15:0] a);
    return (^mem[a] === 1'bx) ? 8'h00 : mem[a];
  endfunction : rdb
  // A released output shows the inverse of its last bit.
  assign o_sdo = sdrv ? sq : !sq;
  always @(negedge i_cs_n) sn = 0;
  // Input taken on rising clock, MSB first; turnaround bits are skipped.
  always @(posedge i_sclk) begin
    if (!i_cs_n) begin
      ssh = {ssh[38:0], i_sdi};
      sn++;
      if (sn == 27) begin
        scmd = ssh[26:24];
        sa = ssh[15:0];
      end
      if (sn >= 40 && sn % 8 == 0 && scmd == HMS_SPI_CMD_WR) begin
        mem[sa] = ssh[7:0];
        sa++;
      end
    end
  end
  // Read data launched on falling clock, one byte per 8 clocks.
  always @(negedge i_sclk or posedge i_cs_n) begin
    sdrv = !i_cs_n && scmd == HMS_SPI_CMD_RD && sn >= 32;
    if (sdrv) begin
      sb = rdb(sa + 16'((sn - 32) / 8));
      sq = sb[7 - (sn - 32) % 8];
    end
  end
  // Frames start after 32 ones and 01; only ports 1 to 5 answer.
  always @(posedge i_mdc) begin
    mh = {mh[62:0], i_mdio};
    if (mn == 0) begin
      if (mh[33:0] == {HMS_MDIO_PRE, HMS_MDIO_ST}) mn = 2;
    end else mn++;
    if (mn == 14) begin
      ok = mh[9:5] >= HMS_MDIO_PHY_MIN && mh[9:5] <= HMS_MDIO_PHY_MAX;
      ma = {mh[8:5], 12'h100} + 16'({mh[4:0], 1'b0});
      mrd = ok && mh[11:10] == HMS_MDIO_OP_RD;
      mwr = ok && mh[11:10] == HMS_MDIO_OP_WR;
      rd = {rdb(ma), rdb(ma + 16'h1)};
    end
    if (mn == 32) begin
      if (mwr) {mem[ma], mem[ma + 16'h1]} = mh[15:0];
      mn = 0;
      mrd = 1'b0;
    end
  end
  // Open drain: the line is only pulled low, from the second turnaround bit.
  always @(negedge i_mdc)
    o_mdio_pull = mrd && mn >= 15 && (mn == 15 || !rd[31 - mn]);
endmodule : hms_dev_model
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the host-side management serial controller.
`timescale 1ns/1ps
`default_nettype none
module testbench import hms_pkg::*; ;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, vld = 1'b0, inb = 1'b0;
  hms_req_t req = '0;
  logic rdy, rv, sclk, cs_n, serial_in_line, serial_out_line, sda_oe, mdc, mo, moe, pull;
  logic scl_oe, scl_o, sda_o;
  hms_rsp_t rsp;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  // MDIO has a pull-up; SDA has no device, so every ack stays high.
  wire logic mdio_w = moe ? mo : !pull;
  always #2 i_clk = ~i_clk;
  hms_host i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1),
    .i_req_valid(vld), .i_req(req), .i_inband_active(inb), .o_req_ready(rdy),
    .o_rsp_valid(rv), .o_rsp(rsp), .o_spi_sclk(sclk), .o_spi_chip_select_n(cs_n),
    .o_serial_in_line(serial_in_line), .i_serial_out_line(serial_out_line), .o_twi_scl_o(scl_o),
    .o_twi_scl_oe(scl_oe), .o_twi_sda_o(sda_o), .o_twi_sda_oe(sda_oe),
    .i_twi_sda_i(!sda_oe), .o_mdc(mdc), .o_mdio_o(mo), .o_mdio_oe(moe),
    .i_mdio_i(mdio_w));
  hms_dev_model i_dev (.i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(serial_in_line), .o_sdo(serial_out_line),
    .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio_pull(pull));
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // One request from a falling edge; writes are judged on err alone.
  task automatic xfer(input logic [1:0] m, input logic w, input logic [15:0] a,
                      input logic [15:0] d, input logic [16:0] exp);
    int n;
    n = 0;
    vld = 1'b1;
    req = '{mode: m, write: w, addr: a, wdata: d};
    @(posedge i_clk);
    while (!rdy && n < 100) begin
      n++;
      @(posedge i_clk);
    end
    @(negedge i_clk);
    vld = 1'b0;
    while (rv !== 1'b1 && n < 9000) begin
      n++;
      @(negedge i_clk);
    end
    // A missing answer must not let a stale response pass as the result.
    if (rv !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: no answer to request", $time);
    end
    chk(w ? {rsp.err, 16'h0} : m == HMS_MODE_MDIO ? rsp :
        {rsp.err, 8'h00, rsp.rdata[7:0]}, exp);
    @(negedge i_clk);
  endtask : xfer
  task automatic t_spi_mdio;
    xfer(HMS_MODE_SPI, 1'b1, 16'h3104, 16'h00A5, 17'h0);
    xfer(HMS_MODE_SPI, 1'b1, 16'h3105, 16'h003C, 17'h0);
    xfer(HMS_MODE_SPI, 1'b0, 16'h3104, 16'h0, 17'h000A5);
    xfer(HMS_MODE_MDIO, 1'b0, 16'h0062, 16'h0, 17'h0A53C);
    xfer(HMS_MODE_MDIO, 1'b1, 16'h00A0, 16'h1234, 17'h0);
    xfer(HMS_MODE_SPI, 1'b0, 16'h5101, 16'h0, 17'h00034);
    $display("Test spi_mdio done");
  endtask : t_spi_mdio
  task automatic t_refuse;
    inb = 1'b1;
    xfer(HMS_MODE_MDIO, 1'b0, 16'h0062, 16'h0, 17'h10000);
    inb = 1'b0;
    xfer(HMS_MODE_MDIO, 1'b0, 16'h0002, 16'h0, 17'h10000);
    xfer(HMS_MODE_MDIO, 1'b1, 16'h00C2, 16'h1, 17'h10000);
    xfer(HMS_MODE_TWI, 1'b1, 16'h0010, 16'h55, 17'h10000);
    xfer(HMS_MODE_TWI, 1'b0, 16'h0010, 16'h0, 17'h10000);
    $display("Test refuse done");
  endtask : t_refuse
  // Cut a hang short well past the expected run of about 19000 cycles.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      $display("Error at %0t: run hung", $time);
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (2) @(negedge i_clk);
    chk({9'h0, cs_n, sclk, mdc, moe, sda_oe, scl_oe, scl_o, sda_o},
        17'h080);
    t_spi_mdio();
    t_refuse();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
